// ---- verilog/sleep_ctrl.sv ----
// sleep mode controller: clock gating, wake-up and module power while asleep
// How it works
// - if the wake level is gone at resume, wake but skip the interrupt.
// - mode select 11 with a crystal clock source enters standby.
// - standby equals power-down except the main oscillator keeps running.
// - a wake-up from standby resumes execution after six clock cycles.
// - deep modes accept only the low level on the external line.
// - an enabled converter stays powered in every sleep mode.
// - after converter off then on, the next conversion is extended.
// - comparator is switched off automatically in power-down and standby.
// - comparator using the reference keeps it on in any sleep mode.
// - a fuse-enabled brown-out detector stays active in every mode.
// - an enabled watchdog keeps running in all sleep modes.
// - reference is on while brown-out, comparator or converter needs it.
// - input buffers are off when io and converter clocks both stop.
// - buffers needed for an enabled wake source stay on.
// - mode select 00 idle, 01 noise reduction, 10 power-down.
// - power-down wake waits the fuse-selected reset time-out.
`timescale 1ns/100ps
`default_nettype none
module sleep_ctrl
   import sleep_pkg::*;
#(
   parameter int PDOWN_XTAL_CYCLES = 16384,
   parameter int PDOWN_RC_CYCLES   = 64
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   input  wire logic        sleep_instr,
   input  wire logic [3:0]  clock_source_fuses,
   input  wire logic        brownout_enable_fuse,
   input  wire logic        ext_irq_line_zero,
   input  wire logic        pin_change_req,
   input  wire logic        usi_start,
   input  wire logic        eeprom_ready,
   input  wire logic        adc_done,
   input  wire logic        other_io_irq,
   input  wire logic        adc_conv_start,
   output logic             cpu_clk_en,
   output logic             flash_clk_en,
   output logic             io_clk_en,
   output logic             adc_clk_en,
   output logic             osc_en,
   output logic             adc_power,
   output logic             comp_power,
   output logic             bod_power,
   output logic             ref_power,
   output logic             wdt_run,
   output logic             input_buf_en,
   output logic             ext_buf_en,
   output logic             pcint_buf_en,
   output logic             adc_extended,
   output logic             cpu_resume,
   output logic             irq_service
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      phase_e                phase;
      sleep_kind_e           kind;
      logic [CTRL_WIDTH-1:0] ctrl;
      logic                  ext_prev;
      logic                  cause_level;
      logic                  ack;
      logic [31:0]           dat;
      logic                  cpu_clk;
      logic                  flash_clk;
      logic                  io_clk;
      logic                  adc_clk;
      logic                  osc;
      logic                  adc_pwr;
      logic                  comp_pwr;
      logic                  bod_pwr;
      logic                  ref_pwr;
      logic                  wdt;
      logic                  buf_en;
      logic                  ext_buf;
      logic                  pc_buf;
      logic                  adc_ext;
      logic                  resume;
      logic                  service;
   } ctrl_s;

   ctrl_s                  cur;
   ctrl_s                  next_cur;
   logic [1:0]             pin_level;
   logic [COUNT_WIDTH-1:0] wake_count;
   logic [COUNT_WIDTH-1:0] ref_count;
   logic                   wake_load;
   logic [COUNT_WIDTH-1:0] wake_value;
   logic                   ref_load;

   // crystal clock options; standby is only honoured with one of these
   function automatic logic is_xtal(input logic [3:0] fuses);
      return fuses >= XTAL_FUSE_MIN;
   endfunction

   // true for the modes that stop the io clock
   function automatic logic is_deep(input sleep_kind_e k);
      return k != KIND_IDLE;
   endfunction

   // ************************************************************
   // pin synchronisers and counters
   // ************************************************************
   // the external line and the fuse come from outside the clock domain
   sync_bits u_sync
   (
      .clock (clock),
      .rst_n (rst_n),
      .pin   ({brownout_enable_fuse, ext_irq_line_zero}),
      .level (pin_level)
   );

   down_counter u_wake_cnt
   (
      .clock (clock),
      .rst_n (rst_n),
      .load  (wake_load),
      .value (wake_value),
      .count (wake_count)
   );

   down_counter u_ref_cnt
   (
      .clock (clock),
      .rst_n (rst_n),
      .load  (ref_load),
      .value (COUNT_WIDTH'(REF_STARTUP_CYCLES)),
      .count (ref_count)
   );

   // ************************************************************
   // next-state logic
   // ************************************************************
   logic        ext_low;
   logic        ext_edge;
   logic        ext_level_src;
   logic        pc_src;
   logic        other_src;
   logic        wake_any;
   logic [1:0]  sense;
   sleep_kind_e entry_kind;
   logic        sleeping;
   logic        bus_write;

   always_comb
   begin
      next_cur   = cur;
      sense      = cur.ctrl[CTRL_SENSE_LSB +: 2];
      ext_low    = ~pin_level[0];
      wake_load  = 1'b0;
      wake_value = COUNT_WIDTH'(IDLE_WAKE_CYCLES);
      bus_write  = 1'b0;

      // edge forms of the external line, only honoured in idle
      unique case (sense)
         SENSE_ANY:  ext_edge = pin_level[0] ^ cur.ext_prev;
         SENSE_FALL: ext_edge = cur.ext_prev & ~pin_level[0];
         SENSE_RISE: ext_edge = ~cur.ext_prev & pin_level[0];
         SENSE_LOW:  ext_edge = 1'b0;
      endcase
      next_cur.ext_prev = pin_level[0];

      ext_level_src = cur.ctrl[CTRL_EXT_EN] & (sense == SENSE_LOW) & ext_low;
      ext_edge      = cur.ctrl[CTRL_EXT_EN] & ext_edge & ~is_deep(cur.kind);
      pc_src        = cur.ctrl[CTRL_PCINT_EN] & pin_change_req;

      // wake sources accepted by each mode
      unique case (cur.kind)
         KIND_IDLE:  other_src = usi_start | eeprom_ready | adc_done | other_io_irq;
         KIND_ADCNR: other_src = usi_start | eeprom_ready | adc_done;
         KIND_PDOWN: other_src = usi_start;
         KIND_STBY:  other_src = usi_start;
      endcase
      wake_any = ext_level_src | pc_src | ext_edge | other_src;

      // mode select decode at the sleep instruction
      unique case (cur.ctrl[CTRL_MODE_LSB +: 2])
         2'h0: entry_kind = KIND_IDLE;
         2'h1: entry_kind = KIND_ADCNR;
         2'h2: entry_kind = KIND_PDOWN;
         2'h3: entry_kind = is_xtal(clock_source_fuses) ? KIND_STBY : KIND_PDOWN;
      endcase

      next_cur.resume  = 1'b0;
      next_cur.service = 1'b0;
      unique case (cur.phase)
         PH_RUN:
         begin
            if (sleep_instr && cur.ctrl[CTRL_SLEEP_EN])
            begin
               next_cur.phase = PH_SLEEP;
               next_cur.kind  = entry_kind;
            end
         end
         PH_SLEEP:
         begin
            if (wake_any)
            begin
               next_cur.phase       = PH_WAKE;
               wake_load            = 1'b1;
               // remember whether only a level source woke us
               next_cur.cause_level = ~(ext_edge | other_src);
               unique case (cur.kind)
                  KIND_STBY:  wake_value = COUNT_WIDTH'(STANDBY_WAKE_CYCLES);
                  KIND_PDOWN: wake_value = is_xtal(clock_source_fuses)
                                           ? COUNT_WIDTH'(PDOWN_XTAL_CYCLES)
                                           : COUNT_WIDTH'(PDOWN_RC_CYCLES);
                  KIND_IDLE,
                  KIND_ADCNR: wake_value = COUNT_WIDTH'(IDLE_WAKE_CYCLES);
               endcase
            end
         end
         PH_WAKE:
         begin
            if (wake_count == 16'h0001)
            begin
               next_cur.phase   = PH_RUN;
               next_cur.resume  = 1'b1;
               // a vanished level wakes the core but is not serviced
               next_cur.service = ~cur.cause_level | ext_level_src | pc_src;
            end
         end
         default: next_cur.phase = PH_RUN;    // unused code falls back to running
      endcase

      // clock gating follows the phase being entered
      sleeping = next_cur.phase != PH_RUN;
      next_cur.cpu_clk   = ~sleeping;
      next_cur.flash_clk = ~sleeping;
      next_cur.io_clk    = ~sleeping | (next_cur.kind == KIND_IDLE);
      next_cur.adc_clk   = ~sleeping | (next_cur.kind == KIND_IDLE)
                           | (next_cur.kind == KIND_ADCNR);
      // standby differs from power-down only by the oscillator; waking restarts it
      next_cur.osc       = ~sleeping | (next_cur.kind != KIND_PDOWN)
                           | (next_cur.phase == PH_WAKE);

      // module power while asleep
      next_cur.adc_pwr  = cur.ctrl[CTRL_ADC_EN];
      next_cur.comp_pwr = ~cur.ctrl[CTRL_COMP_DIS]
                          & (~sleeping | (next_cur.kind == KIND_IDLE)
                             | (next_cur.kind == KIND_ADCNR));
      next_cur.bod_pwr  = pin_level[1];
      next_cur.wdt      = cur.ctrl[CTRL_WDT_EN];
      next_cur.ref_pwr  = pin_level[1]
                          | (~cur.ctrl[CTRL_COMP_DIS] & cur.ctrl[CTRL_COMP_REF])
                          | (cur.ctrl[CTRL_ADC_EN] & cur.ctrl[CTRL_ADC_REF]);

      // input buffers: off only when io and converter clocks are both stopped
      next_cur.buf_en  = next_cur.io_clk | next_cur.adc_clk;
      next_cur.ext_buf = next_cur.buf_en | cur.ctrl[CTRL_EXT_EN];
      next_cur.pc_buf  = next_cur.buf_en | cur.ctrl[CTRL_PCINT_EN];

      // ************************************************************
      // wishbone slave: one wait state, ack for a single cycle
      // ************************************************************
      next_cur.ack = wb_cyc & wb_stb & ~cur.ack;
      if (wb_cyc && wb_stb && !cur.ack)
      begin
         unique case (wb_adr)
            CTRL_ADDR:   next_cur.dat = {20'h00000, cur.ctrl};
            STATUS_ADDR: next_cur.dat = {25'h0000000,
                                         cur.buf_en,
                                         cur.adc_ext,
                                         cur.ref_pwr & (ref_count == '0),
                                         cur.kind,
                                         cur.phase};
            default:     next_cur.dat = 32'h00000000;    // unmapped reads as zero
         endcase
      end
      // writes land at the edge the master sees ack
      if (wb_cyc && wb_stb && wb_we && cur.ack && wb_adr == CTRL_ADDR)
      begin
         bus_write = 1'b1;
         if (wb_sel[0])
            next_cur.ctrl[7:0] = wb_dat_w[7:0];
         if (wb_sel[1])
            next_cur.ctrl[CTRL_WIDTH-1:8] = wb_dat_w[CTRL_WIDTH-1:8];
      end

      // converter switched on again: next conversion is extended; set beats clear
      if (next_cur.ctrl[CTRL_ADC_EN] && !cur.ctrl[CTRL_ADC_EN])
         next_cur.adc_ext = 1'b1;
      else if (adc_conv_start)
         next_cur.adc_ext = 1'b0;
   end

   // start-up timer restarts each time the reference is switched on
   assign ref_load = next_cur.ref_pwr & ~cur.ref_pwr;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur           <= '0;
         cur.phase     <= PH_RUN;
         cur.kind      <= KIND_IDLE;
         cur.ctrl      <= CTRL_RESET;
         cur.ext_prev  <= 1'b1;
         cur.cpu_clk   <= 1'b1;
         cur.flash_clk <= 1'b1;
         cur.io_clk    <= 1'b1;
         cur.adc_clk   <= 1'b1;
         cur.osc       <= 1'b1;
         cur.buf_en    <= 1'b1;
         cur.ext_buf   <= 1'b1;
         cur.pc_buf    <= 1'b1;
      end
      else
         cur <= next_cur;
   end

   // ************************************************************
   // outputs, all from flip-flops
   // ************************************************************
   assign wb_dat_r     = cur.dat;
   assign wb_ack       = cur.ack;
   assign cpu_clk_en   = cur.cpu_clk;
   assign flash_clk_en = cur.flash_clk;
   assign io_clk_en    = cur.io_clk;
   assign adc_clk_en   = cur.adc_clk;
   assign osc_en       = cur.osc;
   assign adc_power    = cur.adc_pwr;
   assign comp_power   = cur.comp_pwr;
   assign bod_power    = cur.bod_pwr;
   assign ref_power    = cur.ref_pwr;
   assign wdt_run      = cur.wdt;
   assign input_buf_en = cur.buf_en;
   assign ext_buf_en   = cur.ext_buf;
   assign pcint_buf_en = cur.pc_buf;
   assign adc_extended = cur.adc_ext;
   assign cpu_resume   = cur.resume;
   assign irq_service  = cur.service;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   localparam int STBY_RUN = 6;

   a_standby_six_cycles: assert property (
      (cur.phase == PH_SLEEP && cur.kind == KIND_STBY && wake_any)
      |=> (cur.phase == PH_WAKE)[*6] ##1 (cur.phase == PH_RUN && cur.resume))
      else $error("standby wake not six cycles");
   a_standby_osc_on: assert property (
      (cur.phase == PH_SLEEP && cur.kind == KIND_STBY) |-> osc_en && !io_clk_en)
      else $error("standby gating wrong");
   a_pdown_all_off: assert property (
      (cur.phase == PH_SLEEP && $past(cur.phase) == PH_SLEEP && cur.kind == KIND_PDOWN)
      |-> !osc_en && !cpu_clk_en && !io_clk_en && !adc_clk_en)
      else $error("power-down clocks running");
   a_idle_io_runs: assert property (
      (cur.phase == PH_SLEEP && $past(cur.phase) == PH_SLEEP && cur.kind == KIND_IDLE)
      |-> io_clk_en && !cpu_clk_en && !flash_clk_en)
      else $error("idle gating wrong");
   a_mode_decode: assert property (
      (cur.phase == PH_RUN && sleep_instr && cur.ctrl[CTRL_SLEEP_EN])
      |=> cur.kind == $past(entry_kind) && cur.phase == PH_SLEEP)
      else $error("sleep mode decode wrong");
   a_level_lost: assert property (
      (cur.phase == PH_WAKE && wake_count == 16'h0001 && cur.cause_level
       && !ext_level_src && !pc_src) |=> cpu_resume && !irq_service)
      else $error("vanished wake was serviced");
   a_deep_no_edge: assert property (
      (cur.phase == PH_SLEEP && cur.kind != KIND_IDLE && sense != SENSE_LOW
       && !pc_src && !other_src) |=> cur.phase == PH_SLEEP)
      else $error("edge woke a deep mode");
   a_comp_auto_off: assert property (
      (cur.phase == PH_SLEEP && $past(cur.phase) == PH_SLEEP
       && (cur.kind == KIND_PDOWN || cur.kind == KIND_STBY)) |-> !comp_power)
      else $error("comparator on in deep sleep");
   a_ref_needed: assert property (
      ##1 (ref_power == $past(pin_level[1]
                               | (~cur.ctrl[CTRL_COMP_DIS] & cur.ctrl[CTRL_COMP_REF])
                               | (cur.ctrl[CTRL_ADC_EN] & cur.ctrl[CTRL_ADC_REF]))))
      else $error("reference power wrong");
   a_adc_ext_set: assert property (
      ($rose(cur.ctrl[CTRL_ADC_EN])) |-> adc_extended)
      else $error("extended conversion not flagged");
   a_buf_off: assert property (
      (!io_clk_en && !adc_clk_en) |-> !input_buf_en
      && ext_buf_en == $past(cur.ctrl[CTRL_EXT_EN]))
      else $error("input buffer state wrong");
   a_keep_power: assert property (
      (cur.phase != PH_RUN) |-> adc_power == $past(cur.ctrl[CTRL_ADC_EN])
      && wdt_run == $past(cur.ctrl[CTRL_WDT_EN]) && bod_power == $past(pin_level[1]))
      else $error("module power dropped in sleep");
   a_bus_ack: assert property (
      (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
      else $error("bus ack timing wrong");

   c_standby_wake: cover property (
      cur.phase == PH_WAKE && cur.kind == KIND_STBY ##[1:STBY_RUN] cpu_resume);
   c_pdown_wake: cover property (cur.kind == KIND_PDOWN && cpu_resume);
   c_skip_service: cover property (cpu_resume && !irq_service);
   c_bus_write: cover property (bus_write);
endmodule
`default_nettype wire

// ---- verilog/sleep_pkg.sv ----
// constants, field layout and state types shared by the sleep controller files
`default_nettype none
package sleep_pkg;

   // ************************************************************
   // register map (byte addresses on the wishbone bus)
   // ************************************************************
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;

   // control register field positions
   localparam int CTRL_MODE_LSB  = 0;   // two bits, sleep_mode_select
   localparam int CTRL_SLEEP_EN  = 2;
   localparam int CTRL_ADC_EN    = 3;
   localparam int CTRL_ADC_REF   = 4;
   localparam int CTRL_COMP_DIS  = 5;
   localparam int CTRL_COMP_REF  = 6;
   localparam int CTRL_WDT_EN    = 7;
   localparam int CTRL_SENSE_LSB = 8;   // two bits, external line sense
   localparam int CTRL_EXT_EN    = 10;
   localparam int CTRL_PCINT_EN  = 11;
   localparam int CTRL_WIDTH     = 12;
   localparam logic [11:0] CTRL_RESET = 12'h000;

   // status register field positions
   localparam int STAT_PHASE_LSB = 0;   // two bits
   localparam int STAT_KIND_LSB  = 2;   // two bits
   localparam int STAT_REF_READY = 4;
   localparam int STAT_ADC_EXT   = 5;
   localparam int STAT_BUF_EN    = 6;

   // ************************************************************
   // encodings and timing
   // ************************************************************
   localparam logic [1:0] SENSE_LOW  = 2'h0;
   localparam logic [1:0] SENSE_ANY  = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   // clock source fuse codes at or above this one select a crystal or resonator
   localparam logic [3:0] XTAL_FUSE_MIN = 4'h9;

   localparam int CLOCK_PERIOD_NS     = 40;
   localparam int REF_STARTUP_NS      = 70000;   // longest start-up of the reference
   localparam int REF_STARTUP_CYCLES  = (REF_STARTUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int STANDBY_WAKE_CYCLES = 6;
   localparam int IDLE_WAKE_CYCLES    = 1;
   localparam int COUNT_WIDTH         = 16;

   typedef enum logic [1:0] {KIND_IDLE, KIND_ADCNR, KIND_PDOWN, KIND_STBY} sleep_kind_e;
   typedef enum logic [1:0] {PH_RUN, PH_SLEEP, PH_WAKE} phase_e;

endpackage
`default_nettype wire

// ---- verilog/sync_bits.sv ----
// two flip-flop synchroniser for a small group of pin levels
`timescale 1ns/100ps
`default_nettype none
module sync_bits
   import sleep_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] pin,
   output logic      [1:0] level
);
   typedef struct packed
   {
      logic [1:0] first;
      logic [1:0] second;
   } sync_s;

   sync_s cur;
   sync_s next_cur;

   // first stage feeds only the second stage
   always_comb
   begin
      next_cur.first  = pin;
      next_cur.second = cur.first;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      // the external line idles high; the fuse reads as off until it is seen
      if (!rst_n)
         cur <= {2'h1, 2'h1};
      else
         cur <= next_cur;
   end

   assign level = cur.second;
endmodule
`default_nettype wire

// ---- verilog/down_counter.sv ----
// loadable down counter that stops at zero
`timescale 1ns/100ps
`default_nettype none
module down_counter
   import sleep_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   load,
   input  wire logic [COUNT_WIDTH-1:0] value,
   output logic      [COUNT_WIDTH-1:0] count
);
   typedef struct packed
   {
      logic [COUNT_WIDTH-1:0] count;
   } cnt_s;

   cnt_s cur;
   cnt_s next_cur;

   // a load wins over the decrement
   always_comb
   begin
      next_cur = cur;
      if (load)
         next_cur.count = value;
      else if (cur.count != '0)
         next_cur.count = cur.count - 16'h0001;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign count = cur.count;
endmodule
`default_nettype wire

// ---- tb/ext_line_model.sv ----
// far-side wake source: external line pulled low for a chosen time
`timescale 1ns/100ps
`default_nettype none
module ext_line_model
(
   input  wire logic       clock,
   input  wire logic       fire,
   input  wire logic [7:0] hold,
   output logic            line
);
   logic [7:0] left = 8'h00;
   // a level request wakes the core however short; it is only serviced if held long enough
   always @(posedge clock)
   begin
      if (fire)
         left <= hold;
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
   assign line = (left == 8'h00);
endmodule
`default_nettype wire

// ---- tb/sleep_mode_clock_gating_bench.sv ----
// self-checking bench for the sleep controller
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_clock_gating_bench;
   import sleep_pkg::*;
   logic clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slp = 0, bodf = 1, fire = 0;
   logic [7:0] adr = 8'h00, hold = 8'h00;
   logic [31:0] dat = 32'h0, dat_r;
   logic [3:0] src = 4'h0, sel = 4'h0, fuse = 4'h9;
   logic ack, cpu, fl, io, adc, osc, adcp, cmp, bod, refp, wdt, ibuf, ebuf, pbuf, adcx, res, irq;
   wire logic ext;
   int fails = 0, cmp_count = 0, cycles = 0;
   // short power-down count keeps the run brief
   sleep_ctrl #(.PDOWN_XTAL_CYCLES(20), .PDOWN_RC_CYCLES(8)) i_dut (.clock(clock), .rst_n(rst_n),
      .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dat),
      .wb_dat_r(dat_r), .wb_ack(ack), .sleep_instr(slp), .clock_source_fuses(fuse),
      .brownout_enable_fuse(bodf), .ext_irq_line_zero(ext), .pin_change_req(1'b0),
      .usi_start(src[3]), .eeprom_ready(src[2]), .adc_done(src[1]), .other_io_irq(src[0]),
      .adc_conv_start(1'b0), .cpu_clk_en(cpu), .flash_clk_en(fl), .io_clk_en(io),
      .adc_clk_en(adc), .osc_en(osc), .adc_power(adcp), .comp_power(cmp), .bod_power(bod),
      .ref_power(refp), .wdt_run(wdt), .input_buf_en(ibuf), .ext_buf_en(ebuf),
      .pcint_buf_en(pbuf), .adc_extended(adcx), .cpu_resume(res), .irq_service(irq));
   ext_line_model i_ext (.clock(clock), .fire(fire), .hold(hold), .line(ext));
   always #20 clock = ~clock;
   // a hang counts as a mismatch and ends the run
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fails++;
         summarize();
      end
   end
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // classic cycle: hold the request until ack is sampled high
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      cyc <= 1;
      stb <= 1;
      we <= w;
      sel <= 4'h3;
      adr <= a;
      dat <= d;
      do @(posedge clock); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 0;
      stb <= 0;
   endtask
   // enter sleep, then count cycles from wake sample to resume
   task automatic sleep_case(logic [11:0] c, logic [4:0] ck, logic bf, int ne, int si, int hd);
      logic [31:0] q;
      int n = 0;
      bus(1, CTRL_ADDR, {20'h0, c}, q);
      @(posedge clock);
      slp <= 1;
      @(posedge clock);
      slp <= 0;
      #1;
      chk("clocks", {3'h0, ck}, {3'h0, cpu, fl, io, adc, osc});
      chk("input buffers", {7'h0, bf}, {7'h0, ibuf});
      chk("watchdog and brown-out", 8'h03, {6'h0, wdt, bod});
      chk("comparator and converter", {6'h0, bf, 1'b0}, {6'h0, cmp, adcp});
      chk("reference and pin-change buffer", {6'h0, 1'b1, bf}, {6'h0, refp, pbuf});
      @(posedge clock);
      if (hd > 0)
      begin
         chk("ext buffer", 8'h01, {7'h0, ebuf});
         fire <= 1;
         hold <= 8'(hd);
      end
      else
         src[si] <= 1;
      @(posedge clock);
      fire <= 0;
      src <= 4'h0;
      while (res !== 1'b1 && n < 100)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      if (hd == 0)
         chk("resume delay", 8'(ne), 8'(n));
      chk("irq service", 8'(hd != 3), {7'h0, irq});
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      logic [31:0] q;
      repeat (3) @(posedge clock);
      rst_n <= 1;
      repeat (3) @(posedge clock);
      bus(0, STATUS_ADDR, 32'h0, q);
      chk("reference ready early", 8'h00, {7'h0, q[STAT_REF_READY]});
      bus(0, 8'h08, 32'h0, q);
      chk("unmapped read", 8'h00, q[7:0]);
      sleep_case(12'h084, 5'h07, 1, 1, 0, 0);
      sleep_case(12'h085, 5'h03, 1, 1, 3, 0);
      sleep_case(12'h086, 5'h00, 0, 20, 3, 0);
      sleep_case(12'h087, 5'h01, 0, 6, 3, 0);
      sleep_case(12'h486, 5'h00, 0, 0, 0, 24);
      sleep_case(12'h486, 5'h00, 0, 0, 0, 3);
      // mode 11 without a crystal source falls back to power-down
      fuse <= 4'h2;
      sleep_case(12'h087, 5'h00, 0, 8, 3, 0);
      bus(1, CTRL_ADDR, 32'h00000008, q);
      #1;
      chk("extended conversion", 8'h01, {7'h0, adcx});
      repeat (1800) @(posedge clock);
      bus(0, STATUS_ADDR, 32'h0, q);
      chk("status ready and extended", 8'h03, {6'h0, q[STAT_ADC_EXT], q[STAT_REF_READY]});
      summarize();
   end
endmodule
`default_nettype wire
